// ==== intc_flag_enable_prio.sv ====
// request flags, enables, priorities and arbitration behind an avalon-mm slave
//
// Overview of operation
// - flag reads one once request recorded
// - flags0 upper byte: conv, serial, sync, timer3
// - flags0 lower byte: timer2, captures, compares, ext0
// - unimplemented bits always read zero
// - flags1: ext2, capture8/7, ext1, change, two-wire
// - flags4 holds only serial error bit1
// - enable one lets request proceed
// - enables0 mirrors flags0 bit layout
// - enables1 mirrors flags1 bit layout
// - enables4 holds only serial error enable
// - prios0 four 3-bit fields, zero disables
// - hardware sets flag, software clears it
// - every source has a 3-bit priority field: seven levels, zero off
`timescale 1ns/1ps
module intc_flag_enable_prio
  import intc_pkg::*;
#(
  parameter int EXT_DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [intc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [intc_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [intc_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [intc_pkg::REG_W-1:0] i_src_req_0,
  input wire logic [intc_pkg::REG_W-1:0] i_src_req_1,
  input wire logic [intc_pkg::REG_W-1:0] i_src_req_4,
  output logic o_cpu_req,
  output logic [intc_pkg::PRIO_W-1:0] o_cpu_level,
  output logic [intc_pkg::ID_W-1:0] o_cpu_src,
  output logic o_irq
);
  import intc_pkg::*;

  logic [REG_W-1:0] flags_0_r, flags_1_r, flags_4_r;
  logic [REG_W-1:0] flags_0_nxt, flags_1_nxt, flags_4_nxt;
  logic [REG_W-1:0] en_0_r, en_1_r, en_4_r;
  logic [REG_W-1:0] en_0_nxt, en_1_nxt, en_4_nxt;
  logic [REG_W-1:0] prios_0_r, prios_0_nxt;
  logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic cpu_req_r, cpu_req_nxt, irq_r, irq_nxt;
  logic [PRIO_W-1:0] lvl_r, lvl_nxt;
  logic [ID_W-1:0] src_r, src_nxt;
  logic any_pend_prev_r, any_pend;
  logic wr_go, rd_go;
  logic [REG_W-1:0] wlo;
  logic ext_we;
  logic [ID_W-1:0] ext_waddr;
  logic [PRIO_W-1:0] ext_wdata;
  logic [PRIO_W*EXT_DEPTH-1:0] ext_all;
  logic [2*REG_W-1:0] pend_vec;
  logic [PRIO_W-1:0] best_lvl;
  logic [ID_W-1:0] best_src;

  // merge write data under the two low byte enables
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [REG_W-1:0] wd,
                                             input logic [1:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // hardware set beats software clear so no event is lost
  function automatic logic [REG_W-1:0] flag_next(input logic [REG_W-1:0] old,
                                                 input logic [REG_W-1:0] req,
                                                 input logic [REG_W-1:0] wval,
                                                 input logic wr,
                                                 input logic [REG_W-1:0] msk);
    flag_next = ((wr ? wval : old) | req) & msk;
  endfunction

  // one-cycle waitrequest: a write is taken on the edge where ack_r is high, ending its waitrequest-low cycle
  assign wr_go = i_avs_write & ack_r;
  // read data is registered on the edge before the taking edge, while waitrequest is still high, so it stands while waitrequest is low
  assign rd_go = i_avs_read & ~ack_r;
  assign wlo = i_avs_writedata[REG_W-1:0];

  // register writes and flag updates
  always_comb begin
    flags_0_nxt = flag_next(flags_0_r, i_src_req_0,
                            merge(flags_0_r, wlo, i_avs_byteenable[1:0]),
                            wr_go && i_avs_address == OFS_FLAGS_0, MASK_FLAGS_0);
    flags_1_nxt = flag_next(flags_1_r, i_src_req_1,
                            merge(flags_1_r, wlo, i_avs_byteenable[1:0]),
                            wr_go && i_avs_address == OFS_FLAGS_1, MASK_FLAGS_1);
    flags_4_nxt = flag_next(flags_4_r, i_src_req_4,
                            merge(flags_4_r, wlo, i_avs_byteenable[1:0]),
                            wr_go && i_avs_address == OFS_FLAGS_4, MASK_FLAGS_4);
    en_0_nxt = en_0_r;
    en_1_nxt = en_1_r;
    en_4_nxt = en_4_r;
    prios_0_nxt = prios_0_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_go) begin
      unique case (i_avs_address)
        OFS_ENABLES_0: en_0_nxt = merge(en_0_r, wlo, i_avs_byteenable[1:0]) & MASK_FLAGS_0;
        OFS_ENABLES_1: en_1_nxt = merge(en_1_r, wlo, i_avs_byteenable[1:0]) & MASK_FLAGS_1;
        OFS_ENABLES_4: en_4_nxt = merge(en_4_r, wlo, i_avs_byteenable[1:0]) & MASK_FLAGS_4;
        OFS_PRIOS_0: prios_0_nxt = merge(prios_0_r, wlo, i_avs_byteenable[1:0]) & MASK_PRIOS;
        OFS_IRQ_MASK: irq_mask_nxt = i_avs_writedata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // extended priority store: write data bits 2:0 to entry given by bits 20:16
  assign ext_we = wr_go && i_avs_address == OFS_PRIOS_EXT && i_avs_byteenable[0];
  assign ext_waddr = i_avs_writedata[REG_W +: ID_W];
  assign ext_wdata = i_avs_writedata[PRIO_W-1:0];

  intc_prio_store #(
    .DEPTH(EXT_DEPTH),
    .AW(ID_W),
    .W(PRIO_W)
  ) u_store (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_we(ext_we),
    .i_waddr(ext_waddr),
    .i_wdata(ext_wdata),
    .i_rst_val(RST_PRIO),
    .o_all(ext_all)
  );

  // priority of a flat source index: first four from prios0, rest from store
  function automatic logic [PRIO_W-1:0] prio_of(input int idx);
    logic [PRIO_W-1:0] p;
    p = ext_all[idx*PRIO_W +: PRIO_W];
    if (idx == 0) p = prios_0_r[2:0];
    if (idx == 1) p = prios_0_r[6:4];
    if (idx == 2) p = prios_0_r[10:8];
    if (idx == 3) p = prios_0_r[14:12];
    prio_of = p;
  endfunction

  // pending sources and arbitration; lowest index wins a tie, like natural order
  always_comb begin
    pend_vec = {flags_1_r & en_1_r, flags_0_r & en_0_r};
    // serial error has no slot of its own; it borrows the unused flags1 bit 2 index
    pend_vec[SRC_F1_LO + 2] = flags_4_r[1] & en_4_r[1];
    best_lvl = PRIO_OFF;
    best_src = ID_NONE;
    for (int i = 2*REG_W-1; i >= 0; i--) begin
      if (pend_vec[i] && prio_of(i) != PRIO_OFF && prio_of(i) >= best_lvl) begin
        best_lvl = prio_of(i);
        best_src = ID_W'(i);
      end
    end
  end

  assign any_pend = best_lvl != PRIO_OFF;

  // outputs toward cpu and interrupt status
  always_comb begin
    cpu_req_nxt = any_pend;
    lvl_nxt = best_lvl;
    src_nxt = best_src;
    irq_stat_nxt = irq_stat_r;
    if (wr_go && i_avs_address == OFS_IRQ_STATUS) begin
      irq_stat_nxt = irq_stat_r & ~i_avs_writedata[IRQ_W-1:0];
    end
    if (any_pend && !any_pend_prev_r) irq_stat_nxt[IRQ_NEW_REQ] = 1'b1;
    if (wr_go && i_avs_address > OFS_WINNER) irq_stat_nxt[IRQ_WRITE_ERR] = 1'b1;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rdata_nxt = '0;
    ack_nxt = (i_avs_read | i_avs_write) & ~ack_r;
    if (rd_go) begin
      unique case (i_avs_address)
        OFS_FLAGS_0: rdata_nxt[REG_W-1:0] = flags_0_r;
        OFS_FLAGS_1: rdata_nxt[REG_W-1:0] = flags_1_r;
        OFS_FLAGS_4: rdata_nxt[REG_W-1:0] = flags_4_r;
        OFS_ENABLES_0: rdata_nxt[REG_W-1:0] = en_0_r;
        OFS_ENABLES_1: rdata_nxt[REG_W-1:0] = en_1_r;
        OFS_ENABLES_4: rdata_nxt[REG_W-1:0] = en_4_r;
        OFS_PRIOS_0: rdata_nxt[REG_W-1:0] = prios_0_r;
        OFS_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = irq_stat_r;
        OFS_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = irq_mask_r;
        OFS_WINNER: rdata_nxt[REG_W-1:0] = {3'h0, src_r, 5'h00, lvl_r};
        default: rdata_nxt = '0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flags_0_r <= RST_FLAGS;
      flags_1_r <= RST_FLAGS;
      flags_4_r <= RST_FLAGS;
      en_0_r <= RST_ENABLES;
      en_1_r <= RST_ENABLES;
      en_4_r <= RST_ENABLES;
      prios_0_r <= RST_PRIOS_0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      rdata_r <= '0;
      ack_r <= 1'b0;
      cpu_req_r <= 1'b0;
      lvl_r <= PRIO_OFF;
      src_r <= ID_NONE;
      irq_r <= 1'b0;
      any_pend_prev_r <= 1'b0;
    end else begin
      flags_0_r <= flags_0_nxt;
      flags_1_r <= flags_1_nxt;
      flags_4_r <= flags_4_nxt;
      en_0_r <= en_0_nxt;
      en_1_r <= en_1_nxt;
      en_4_r <= en_4_nxt;
      prios_0_r <= prios_0_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      cpu_req_r <= cpu_req_nxt;
      lvl_r <= lvl_nxt;
      src_r <= src_nxt;
      irq_r <= irq_nxt;
      any_pend_prev_r <= any_pend;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = ~ack_r;
  assign o_cpu_req = cpu_req_r;
  assign o_cpu_level = lvl_r;
  assign o_cpu_src = src_r;
  assign o_irq = irq_r;
endmodule

// ==== intc_monitor.sv ====
// checker: read masks and cpu request relations of the flag block
`timescale 1ns/1ps
module intc_monitor
  import intc_pkg::*;
#(
  parameter int EXT_DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [intc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [intc_pkg::DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_cpu_req,
  input wire logic [intc_pkg::PRIO_W-1:0] o_cpu_level,
  input wire logic [intc_pkg::ID_W-1:0] o_cpu_src
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // a read is answered in the cycle that waitrequest is low
  sequence rd_at(logic [3:0] ofs);
    !o_avs_waitrequest && i_avs_read && i_avs_address == ofs;
  endsequence
  property rd_mask(logic [3:0] ofs, logic [15:0] m);
    rd_at(ofs) |-> (o_avs_readdata[15:0] & ~m) == 16'h0000;
  endproperty
  // spare positions never leak into read data
  upper_zero_a: assert property (!o_avs_waitrequest && i_avs_read |->
    o_avs_readdata[31:16] == 16'h0000) else $error("upper read half not zero");
  flags0_spare_a: assert property (rd_mask(OFS_FLAGS_0, 16'h3FEF))
    else $error("flags0 spare bit set");
  flags1_spare_a: assert property (rd_mask(OFS_FLAGS_1, 16'h20DB))
    else $error("flags1 spare bit set");
  flags4_spare_a: assert property (rd_mask(OFS_FLAGS_4, 16'h0002))
    else $error("flags4 spare bit set");
  en4_spare_a: assert property (rd_mask(OFS_ENABLES_4, 16'h0002))
    else $error("enables4 spare bit set");
  prio_spare_a: assert property (rd_mask(OFS_PRIOS_0, 16'h7777))
    else $error("prios0 spare bit set");
  // request and level travel together; no winner means the idle index
  req_level_a: assert property (o_cpu_req == (o_cpu_level != PRIO_OFF))
    else $error("cpu request and level disagree");
  src_idle_a: assert property (!o_cpu_req |-> o_cpu_src == ID_NONE)
    else $error("source index not idle");
  // a recorded request only goes away after software wrote something
  req_sticky_a: assert property ($fell(o_cpu_req) |-> $past(i_avs_write) ||
    $past(i_avs_write, 2) || $past(i_avs_write, 3)) else $error("request dropped alone");
endmodule
bind intc_flag_enable_prio intc_monitor #(.EXT_DEPTH(EXT_DEPTH)) u_monitor (
  .i_clk(i_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_cpu_req(o_cpu_req),
  .o_cpu_level(o_cpu_level), .o_cpu_src(o_cpu_src));

// ==== intc_periph_model.sv ====
// peripheral model: raises one-cycle event strobes in flag layout
`timescale 1ns/1ps
module intc_periph_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_pat_0,
  input wire logic [15:0] i_pat_1,
  input wire logic [15:0] i_pat_4,
  output logic [15:0] o_req_0,
  output logic [15:0] o_req_1,
  output logic [15:0] o_req_4
);
  // strobe lasts one cycle, so only a sticky flag can remember it
  always_ff @(posedge i_clk) begin
    o_req_0 <= i_go ? i_pat_0 : 16'h0000;
    o_req_1 <= i_go ? i_pat_1 : 16'h0000;
    o_req_4 <= i_go ? i_pat_4 : 16'h0000;
  end
endmodule

// ==== intc_pkg.sv ====
// package: register map, field layout and reset values of the request bookkeeping block
package intc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int NUM_SRC = 21;
  localparam int PRIO_W = 3;
  // word offsets on the avalon bus
  localparam logic [ADDR_W-1:0] OFS_FLAGS_0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_1 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_4 = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_ENABLES_0 = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_ENABLES_1 = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ENABLES_4 = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_PRIOS_0 = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_PRIOS_EXT = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_WINNER = 4'hA;
  // implemented bit masks
  localparam logic [REG_W-1:0] MASK_FLAGS_0 = 16'h3FEF;
  localparam logic [REG_W-1:0] MASK_FLAGS_1 = 16'h20DB;
  localparam logic [REG_W-1:0] MASK_FLAGS_4 = 16'h0002;
  localparam logic [REG_W-1:0] MASK_PRIOS = 16'h7777;
  localparam logic [REG_W-1:0] RST_FLAGS = 16'h0000;
  localparam logic [REG_W-1:0] RST_ENABLES = 16'h0000;
  localparam logic [REG_W-1:0] RST_PRIOS_0 = 16'h4444;
  localparam logic [PRIO_W-1:0] RST_PRIO = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  // source index of bit positions in the flat source vector
  localparam int SRC_F0_LO = 0;
  localparam int SRC_F1_LO = 16;
  localparam int IRQ_W = 2;
  localparam int IRQ_NEW_REQ = 0;
  localparam int IRQ_WRITE_ERR = 1;
  localparam int ID_W = 5;
  localparam logic [ID_W-1:0] ID_NONE = 5'h1F;
  localparam logic [1:0] WS_IDLE = 2'b00;
endpackage

// ==== intc_prio_store.sv ====
// little memory holding 3-bit priority fields for the sources beyond the first priority register
`timescale 1ns/1ps
module intc_prio_store #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int W = 3
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [W-1:0] i_rst_val,
  output logic [W*DEPTH-1:0] o_all
);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  // write port; whole contents exposed for arbitration
  always_comb begin
    for (int k = 0; k < DEPTH; k++) begin
      mem_nxt[k] = mem_r[k];
    end
    if (i_we) begin
      mem_nxt[i_waddr] = i_wdata;
    end
  end
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < DEPTH; k++) begin
      mem_r[k] <= i_srst ? i_rst_val : mem_nxt[k];
    end
  end
  always_comb begin
    for (int k = 0; k < DEPTH; k++) begin
      o_all[k*W +: W] = mem_r[k];
    end
  end
endmodule

// ==== tb_interrupt_flag_enable_priority.sv ====
// testbench: register map, sticky flags, arbitration and irq of the flag block
`timescale 1ns/1ps
module tb_interrupt_flag_enable_priority;
  import intc_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic we = 1'b0;
  logic go = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [15:0] p0 = 16'h0000;
  logic [15:0] p1 = 16'h0000;
  logic [15:0] p4 = 16'h0000;
  logic [15:0] r0, r1, r4;
  logic [31:0] rdq, rdata;
  logic wreq, creq, irq;
  logic [2:0] lvl;
  logic [4:0] src;
  int mismatches = 0;
  int compares = 0;
  logic [3:0] ofs [7] = '{OFS_FLAGS_0, OFS_FLAGS_1, OFS_FLAGS_4, OFS_ENABLES_0,
    OFS_ENABLES_1, OFS_ENABLES_4, OFS_PRIOS_0};
  logic [15:0] msk [7] = '{16'h3FEF, 16'h20DB, 16'h0002, 16'h3FEF, 16'h20DB,
    16'h0002, 16'h7777};
  // free-running 10 MHz clock
  always #50 i_clk = ~i_clk;
  intc_periph_model u_periph (.i_clk(i_clk), .i_go(go), .i_pat_0(p0), .i_pat_1(p1),
    .i_pat_4(p4), .o_req_0(r0), .o_req_1(r1), .o_req_4(r4));
  intc_flag_enable_prio DUT (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(we), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdq), .o_avs_waitrequest(wreq), .i_src_req_0(r0), .i_src_req_1(r1),
    .i_src_req_4(r4), .o_cpu_req(creq), .o_cpu_level(lvl), .o_cpu_src(src), .o_irq(irq));
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    addr <= a;
    wd <= d;
    rd <= !w;
    we <= w;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (wreq === 1'b0) break;
    end
    rdata = rdq;
    rd <= 1'b0;
    we <= 1'b0;
    if (n == 20) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdata);
  endtask
  // outputs are registered, so allow a few cycles to settle before comparing
  task automatic outs(input logic [9:0] e);
    int n;
    for (n = 0; n < 8 && {irq, creq, lvl, src} !== e; n++) @(posedge i_clk);
    chk("irq req level src", {22'h0, e}, {22'h0, irq, creq, lvl, src});
  endtask
  task automatic fire(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge i_clk);
    go <= 1'b1;
    p0 <= a;
    p1 <= b;
    p4 <= c;
    @(posedge i_clk);
    go <= 1'b0;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rdchk(ofs[i], (i == 6) ? 32'h0000_4444 : 32'h0000_0000, "reset value");
    end
    outs(10'h01F);
  endtask
  // all ones in, only implemented positions come back
  task automatic t_layout();
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, ofs[i], 32'hFFFF_FFFF);
      rdchk(ofs[i], {16'h0000, msk[i]}, "implemented bits");
      bus(1'b1, ofs[i], 32'h0000_0000);
    end
  endtask
  // event strobes are gone long before the read, the flags must remember
  task automatic t_flags();
    fire(16'hFFFF, 16'hFFFF, 16'hFFFF);
    for (int i = 0; i < 3; i++) rdchk(ofs[i], {16'h0000, msk[i]}, "flags set");
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, ofs[i], 32'h0000_0000);
      rdchk(ofs[i], 32'h0000_0000, "flags cleared");
    end
  endtask
  task automatic t_arb();
    bus(1'b1, OFS_PRIOS_0, 32'h0000_2005);
    bus(1'b1, OFS_ENABLES_0, 32'h0000_0009);
    fire(16'h0009, 16'h0000, 16'h0000);
    outs(10'h1A0);
    bus(1'b1, OFS_PRIOS_0, 32'h0000_2000);
    outs(10'h143);
    bus(1'b1, OFS_ENABLES_0, 32'h0000_0001);
    outs(10'h01F);
  endtask
  task automatic t_irq();
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0003);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    bus(1'b1, OFS_ENABLES_0, 32'h0000_0009);
    outs(10'h343);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    outs(10'h143);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0001, "status sticky");
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0000, "status cleared");
    bus(1'b1, 4'hB, 32'h0000_1234);
    rdchk(4'hC, 32'h0000_0000, "unmapped read");
    rdchk(OFS_IRQ_STATUS, 32'h0000_0002, "bad write status");
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
    outs(10'h343);
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0002);
    outs(10'h143);
  endtask
  // sources beyond the first priority register, the winner register and equal levels
  task automatic t_ext();
    bus(1'b1, OFS_PRIOS_EXT, 32'h0012_0007);
    bus(1'b1, OFS_ENABLES_4, 32'h0000_0002);
    fire(16'h0000, 16'h0000, 16'h0002);
    outs(10'h1F2);
    rdchk(OFS_WINNER, 32'h0000_1207, "winner register");
    bus(1'b1, OFS_PRIOS_EXT, 32'h0012_0000);
    outs(10'h143);
    bus(1'b1, OFS_ENABLES_1, 32'h0000_0001);
    fire(16'h0000, 16'h0001, 16'h0000);
    outs(10'h190);
    bus(1'b1, OFS_PRIOS_0, 32'h0000_4000);
    outs(10'h183);
    bus(1'b1, OFS_FLAGS_0, 32'h0000_0000);
    outs(10'h190);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_layout();
    t_flags();
    t_arb();
    t_irq();
    t_ext();
    close_out();
  end
endmodule
